// >>> src/brp_boot_reset_power.sv
// Boot source select, resets, watchdog and power mode control
`timescale 1ns/10ps
module brp_boot_reset_power
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Pins
    input wire logic hardReset_n,
    input wire logic csiReset,
    input wire logic wdogClkPin,
    input wire brp_pkg::brp_pin_t [2:0] boot_select_straps,
    input wire logic [1:0] refBand,
    input wire logic wakeEvent,
    input wire logic powerDown,
    // Firmware control
    input wire brp_pkg::brp_ctrl_t ctrl,
    // Status
    output brp_pkg::brp_stat_t stat,
    output brp_pkg::brp_boot_t bootSource,
    output brp_pkg::brp_power_t powerMode,
    output logic [5:0] pllMult
);
    // ==================================================
    // Pin synchronisers
    logic hardResetSync_n;
    logic csiResetSync;
    logic wdogClkSync;
    logic wakeSync;
    logic pdSync;
    brp_pkg::brp_pin_t [2:0] strapSync;
    logic [1:0] bandSync;

    brp_sync #(.W(13)) u_sync
    (
        .clk_sys(clk_sys),
        .din({hardReset_n, csiReset, wdogClkPin, wakeEvent, powerDown, boot_select_straps, refBand}),
        .dout({hardResetSync_n, csiResetSync, wdogClkSync, wakeSync, pdSync, strapSync, bandSync})
    );

    // ==================================================
    // Reset and boot select
    logic fullReset;
    logic hardPrev_q;
    logic hardPrev_d;
    brp_pkg::brp_boot_t boot_q;
    brp_pkg::brp_boot_t boot_d;
    logic usbFallback_q;
    logic usbFallback_d;

    assign fullReset = reset | ~hardResetSync_n | ctrl.deviceSoftReset;

    always_comb
    begin
        hardPrev_d = hardResetSync_n;
        boot_d = boot_q;
        usbFallback_d = usbFallback_q;
        if (fullReset)
        begin
            boot_d = brp_pkg::BOOT_NONE;
            usbFallback_d = 1'b0;
        end
        else if (!hardPrev_q || boot_q == brp_pkg::BOOT_NONE)
        begin
            // Latch once at release; held until the next full reset
            if (strapSync[2] == brp_pkg::PIN_FLOAT && strapSync[1] == brp_pkg::PIN_HIGH
                && strapSync[0] == brp_pkg::PIN_HIGH)
                boot_d = brp_pkg::BOOT_USB;
            else if (strapSync[2] == brp_pkg::PIN_FLOAT && strapSync[1] == brp_pkg::PIN_HIGH
                && strapSync[0] == brp_pkg::PIN_FLOAT)
                boot_d = brp_pkg::BOOT_I2C_USB;
            else if (strapSync[2] == brp_pkg::PIN_HIGH && strapSync[1] == brp_pkg::PIN_FLOAT
                && strapSync[0] == brp_pkg::PIN_FLOAT)
                boot_d = brp_pkg::BOOT_I2C_ONLY;
            else if (strapSync[2] == brp_pkg::PIN_LOW && strapSync[1] == brp_pkg::PIN_FLOAT
                && strapSync[0] == brp_pkg::PIN_HIGH)
                boot_d = brp_pkg::BOOT_SPI_USB;
            else
                boot_d = brp_pkg::BOOT_USB;
        end
        else if (ctrl.bootFailed && (boot_q == brp_pkg::BOOT_I2C_USB || boot_q == brp_pkg::BOOT_SPI_USB))
        begin
            usbFallback_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        hardPrev_q <= hardPrev_d;
        boot_q <= boot_d;
        usbFallback_q <= usbFallback_d;
    end

    // ==================================================
    // Watchdog on the 32 kHz pin clock, sampled by clk_sys
    logic wdClkPrev_q;
    logic wdClkPrev_d;
    logic [15:0] wdCount_q;
    logic [15:0] wdCount_d;
    logic wdExpire;
    logic wdTick;

    assign wdTick = wdogClkSync & ~wdClkPrev_q;
    assign wdExpire = wdTick && !ctrl.wdogDisable && wdCount_q == brp_pkg::WDOG_ONE;

    always_comb
    begin
        wdClkPrev_d = wdogClkSync;
        wdCount_d = wdCount_q;
        if (fullReset || ctrl.wdogDisable || ctrl.wdogKick)
            wdCount_d = brp_pkg::WDOG_RELOAD;
        else if (wdTick)
        begin
            if (wdCount_q == brp_pkg::WDOG_ONE || wdCount_q == brp_pkg::WDOG_ZERO)
                wdCount_d = brp_pkg::WDOG_RELOAD;
            else
                wdCount_d = wdCount_q - brp_pkg::WDOG_ONE;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        wdClkPrev_q <= wdClkPrev_d;
        wdCount_q <= wdCount_d;
    end

    // ==================================================
    // Power mode state
    brp_pkg::brp_power_t mode_q;
    brp_pkg::brp_power_t mode_d;
    logic pcPulse;

    always_comb
    begin
        mode_d = mode_q;
        pcPulse = 1'b0;
        if (fullReset)
            mode_d = brp_pkg::PM_NORMAL;
        else
        begin
            unique case (mode_q)
                brp_pkg::PM_NORMAL:
                begin
                    if (pdSync)
                        mode_d = brp_pkg::PM_POWERDOWN;
                    else if (ctrl.enterStandby)
                        mode_d = brp_pkg::PM_STANDBY;
                    else if (ctrl.enterSuspend)
                        mode_d = brp_pkg::PM_SUSPEND;
                end
                brp_pkg::PM_SUSPEND:
                begin
                    // Resume without touching the program counter
                    if (wakeSync)
                        mode_d = brp_pkg::PM_NORMAL;
                end
                brp_pkg::PM_STANDBY:
                begin
                    if (wakeSync || wdExpire)
                    begin
                        mode_d = brp_pkg::PM_NORMAL;
                        pcPulse = 1'b1;
                    end
                end
                brp_pkg::PM_POWERDOWN:
                begin
                    // Leaves only by full reset; firmware is lost
                    mode_d = brp_pkg::PM_POWERDOWN;
                end
                default:
                    mode_d = brp_pkg::PM_NORMAL;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        mode_q <= mode_d;
    end

    // ==================================================
    // Registered outputs
    brp_pkg::brp_stat_t stat_d;
    logic [5:0] mult_d;

    always_comb
    begin
        stat_d.coreReset = fullReset;
        stat_d.ioTristate = fullReset;
        stat_d.firmwareLost = fullReset || mode_q == brp_pkg::PM_POWERDOWN;
        // CPU soft reset: PC only, memory kept
        stat_d.pcReset = fullReset || ctrl.cpuSoftReset || pcPulse || (wdExpire && mode_q == brp_pkg::PM_NORMAL);
        stat_d.wdogIrq = wdExpire && mode_q == brp_pkg::PM_NORMAL;
        stat_d.csiCoreReset = fullReset || csiResetSync;
        stat_d.cpuClockEn = mode_q == brp_pkg::PM_NORMAL;
        stat_d.pllEn = mode_q == brp_pkg::PM_NORMAL || mode_q == brp_pkg::PM_SUSPEND;
        stat_d.usbPhyEn = mode_q == brp_pkg::PM_NORMAL || mode_q == brp_pkg::PM_SUSPEND;
        stat_d.i2cMaster = boot_q == brp_pkg::BOOT_I2C_USB || boot_q == brp_pkg::BOOT_I2C_ONLY;
        stat_d.spiBoot = boot_q == brp_pkg::BOOT_SPI_USB;
        stat_d.usbBootEn = boot_q == brp_pkg::BOOT_USB || usbFallback_q;
        if (bandSync == brp_pkg::BAND_LOW)
            mult_d = brp_pkg::PLL_MULT_LOW;
        else if (bandSync == brp_pkg::BAND_MID)
            mult_d = brp_pkg::PLL_MULT_MID;
        else
            mult_d = brp_pkg::PLL_MULT_HIGH;
    end

    always_ff @(posedge clk_sys)
    begin
        stat <= stat_d;
        bootSource <= boot_q;
        powerMode <= mode_q;
        pllMult <= mult_d;
    end

    // ==================================================
    // Checks
    // Power-down loses firmware anyway, so soft reset is judged outside it
    sequence s_softCpu;
        ctrl.cpuSoftReset && !fullReset && mode_q != brp_pkg::PM_POWERDOWN;
    endsequence

    sequence s_suspendWake;
        mode_q == brp_pkg::PM_SUSPEND && wakeSync && !fullReset;
    endsequence

    sequence s_standbyWake;
        mode_q == brp_pkg::PM_STANDBY && wakeSync && !fullReset;
    endsequence

    chk_cpu_soft_reset: assert property (@(posedge clk_sys) disable iff (reset)
        s_softCpu |=> stat.pcReset && !stat.firmwareLost)
        else $error("cpu soft reset wrong");
    chk_hard_tristate: assert property (@(posedge clk_sys) disable iff (reset)
        fullReset |=> stat.ioTristate && stat.coreReset)
        else $error("tristate missing in reset");
    chk_wdog_disable: assert property (@(posedge clk_sys) disable iff (reset)
        ctrl.wdogDisable |=> wdCount_q == brp_pkg::WDOG_RELOAD && !stat.wdogIrq)
        else $error("watchdog ran while disabled");
    chk_wdog_count: assert property (@(posedge clk_sys) disable iff (reset)
        wdTick && !fullReset && !ctrl.wdogDisable && !ctrl.wdogKick && wdCount_q > brp_pkg::WDOG_ONE
        |=> wdCount_q == $past(wdCount_q) - brp_pkg::WDOG_ONE)
        else $error("watchdog count step wrong");
    chk_suspend_resume: assert property (@(posedge clk_sys) disable iff (reset)
        s_suspendWake |=> mode_q == brp_pkg::PM_NORMAL
        ##1 (!stat.pcReset || $past(ctrl.cpuSoftReset) || $past(fullReset) || $past(wdExpire)))
        else $error("suspend wake wrong");
    chk_standby_wake: assert property (@(posedge clk_sys) disable iff (reset)
        s_standbyWake |=> stat.pcReset && mode_q == brp_pkg::PM_NORMAL)
        else $error("standby wake did not reset pc");
    chk_normal_clocks: assert property (@(posedge clk_sys) disable iff (reset)
        mode_q == brp_pkg::PM_NORMAL |=> stat.cpuClockEn && stat.pllEn)
        else $error("normal mode clocks off");
    chk_boot_held: assert property (@(posedge clk_sys) disable iff (reset)
        hardPrev_q && !fullReset && boot_q != brp_pkg::BOOT_NONE |=> $stable(boot_q))
        else $error("boot source changed");
    chk_csi_reset: assert property (@(posedge clk_sys) disable iff (reset)
        csiResetSync |=> stat.csiCoreReset)
        else $error("camera core reset missing");
endmodule

// >>> src/brp_pkg.sv
// Package for the boot, reset and power control block
package brp_pkg;

    // Strap pattern: each pin is floating, driven low or driven high
    typedef enum logic [1:0]
    {
        PIN_LOW = 2'h0,
        PIN_HIGH = 2'h1,
        PIN_FLOAT = 2'h2
    } brp_pin_t;

    typedef enum logic [2:0]
    {
        BOOT_NONE = 3'h0,
        BOOT_USB = 3'h1,
        BOOT_I2C_USB = 3'h2,
        BOOT_I2C_ONLY = 3'h3,
        BOOT_SPI_USB = 3'h4
    } brp_boot_t;

    typedef enum logic [2:0]
    {
        PM_NORMAL = 3'h0,
        PM_SUSPEND = 3'h1,
        PM_STANDBY = 3'h2,
        PM_POWERDOWN = 3'h3
    } brp_power_t;

    // Soft and firmware control inputs, one set per cycle
    typedef struct packed
    {
        logic cpuSoftReset;
        logic deviceSoftReset;
        logic wdogDisable;
        logic wdogKick;
        logic enterSuspend;
        logic enterStandby;
        logic bootFailed;
    } brp_ctrl_t;

    // Outputs to the rest of the chip
    typedef struct packed
    {
        logic coreReset;
        logic pcReset;
        logic firmwareLost;
        logic ioTristate;
        logic cpuClockEn;
        logic pllEn;
        logic usbPhyEn;
        logic csiCoreReset;
        logic wdogIrq;
        logic i2cMaster;
        logic spiBoot;
        logic usbBootEn;
    } brp_stat_t;

    localparam int CLK_HZ = 50000000;
    localparam int WDOG_HZ = 32768;
    localparam logic [15:0] WDOG_RELOAD = 16'h8000;
    localparam logic [15:0] WDOG_ZERO = 16'h0000;
    localparam logic [15:0] WDOG_ONE = 16'h0001;

    // PLL multiply per input band, chosen so the core rate stays fixed
    localparam logic [5:0] PLL_MULT_LOW = 6'h14;
    localparam logic [5:0] PLL_MULT_MID = 6'h0a;
    localparam logic [5:0] PLL_MULT_HIGH = 6'h05;
    localparam logic [1:0] BAND_LOW = 2'h0;
    localparam logic [1:0] BAND_MID = 2'h1;

endpackage

// >>> src/brp_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module brp_sync #(
    parameter int W = 1
)
(
    // Clock
    input wire logic clk_sys,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys)
    begin
        meta_q <= din;
        dout <= meta_q;
    end
endmodule

// >>> sim/brp_board_model.sv
// Board-side model: reset pins and free-running 32 kHz clock
`timescale 1ns/10ps
module brp_board_model
(
    // Requests from the bench
    input wire logic hardAssert,
    input wire logic csiAssert,
    // Board pins
    output logic hardReset_n,
    output logic csiReset,
    output logic wdogClkPin
);
    // Crystal runs free, never stopped
    localparam real HALF_PERIOD = 15258.79;
    initial wdogClkPin = 1'b0;
    always #(HALF_PERIOD) wdogClkPin = ~wdogClkPin;
    assign hardReset_n = ~hardAssert;
    // Pull-down resistor keeps the camera reset low unless asserted
    assign csiReset = csiAssert;
endmodule

// >>> sim/brp_boot_reset_power_test.sv
// Testbench for the boot, reset and power control block
`timescale 1ns/10ps
module brp_boot_reset_power_test;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hardAssert = 1'b0;
    logic csiAssert = 1'b0;
    logic hardReset_n;
    logic csiReset;
    logic wdogClkPin;
    brp_pkg::brp_pin_t [2:0] straps;
    logic [1:0] refBand = 2'h0;
    logic wakeEvent = 1'b0;
    logic powerDown = 1'b0;
    brp_pkg::brp_ctrl_t ctrl = '0;
    brp_pkg::brp_stat_t stat;
    brp_pkg::brp_boot_t bootSource;
    brp_pkg::brp_power_t powerMode;
    logic [5:0] pllMult;
    logic sawPc = 1'b0;
    logic sawLost = 1'b0;
    logic sawCore = 1'b0;
    logic sawIrq = 1'b0;
    int failures = 0;
    int checks = 0;

    always #10 clk_sys = ~clk_sys;

    // Sticky flags, as some outputs may be short pulses
    always @(posedge clk_sys)
    begin
        if (stat.pcReset === 1'b1) sawPc <= 1'b1;
        if (stat.firmwareLost === 1'b1) sawLost <= 1'b1;
        if (stat.coreReset === 1'b1) sawCore <= 1'b1;
        if (stat.wdogIrq === 1'b1) sawIrq <= 1'b1;
    end

    brp_board_model board (.hardAssert(hardAssert), .csiAssert(csiAssert), .hardReset_n(hardReset_n),
        .csiReset(csiReset), .wdogClkPin(wdogClkPin));

    brp_boot_reset_power dut (.clk_sys(clk_sys), .reset(reset), .hardReset_n(hardReset_n),
        .csiReset(csiReset), .wdogClkPin(wdogClkPin), .boot_select_straps(straps), .refBand(refBand),
        .wakeEvent(wakeEvent), .powerDown(powerDown), .ctrl(ctrl), .stat(stat), .bootSource(bootSource),
        .powerMode(powerMode), .pllMult(pllMult));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic clear_flags();
        sawPc = 1'b0;
        sawLost = 1'b0;
        sawCore = 1'b0;
        sawIrq = 1'b0;
    endtask

    // Strap pattern latched at release, later changes ignored
    task automatic test_boot(input brp_pkg::brp_pin_t p2, p1, p0, input brp_pkg::brp_boot_t exp, input logic i2c,
        input logic spi);
        straps[2] = p2;
        straps[1] = p1;
        straps[0] = p0;
        hardAssert = 1'b1;
        cycles(5);
        check("ioTristate", 8'h01, 8'(stat.ioTristate));
        check("coreReset", 8'h01, 8'(stat.coreReset));
        hardAssert = 1'b0;
        cycles(6);
        straps = '{brp_pkg::PIN_LOW, brp_pkg::PIN_LOW, brp_pkg::PIN_LOW};
        cycles(5);
        check("ioTristate", 8'h00, 8'(stat.ioTristate));
        check("bootSource", 8'(exp), 8'(bootSource));
        check("i2cMaster", 8'(i2c), 8'(stat.i2cMaster));
        check("spiBoot", 8'(spi), 8'(stat.spiBoot));
    endtask

    task automatic test_fallback(input logic exp);
        ctrl.bootFailed = 1'b1;
        cycles(1);
        ctrl.bootFailed = 1'b0;
        cycles(4);
        check("usbBootEn", 8'(exp), 8'(stat.usbBootEn));
    endtask

    task automatic test_soft();
        clear_flags();
        ctrl.cpuSoftReset = 1'b1;
        cycles(1);
        ctrl.cpuSoftReset = 1'b0;
        cycles(4);
        check("cpu pcReset", 8'h01, 8'(sawPc));
        check("cpu firmwareLost", 8'h00, 8'(sawLost));
        check("cpu coreReset", 8'h00, 8'(sawCore));
        clear_flags();
        ctrl.deviceSoftReset = 1'b1;
        cycles(1);
        ctrl.deviceSoftReset = 1'b0;
        cycles(10);
        check("dev firmwareLost", 8'h01, 8'(sawLost));
        check("dev coreReset", 8'h01, 8'(sawCore));
    endtask

    task automatic test_csi();
        csiAssert = 1'b1;
        cycles(5);
        check("csiCoreReset", 8'h01, 8'(stat.csiCoreReset));
        check("coreReset", 8'h00, 8'(stat.coreReset));
        csiAssert = 1'b0;
        cycles(5);
        check("csiCoreReset", 8'h00, 8'(stat.csiCoreReset));
    endtask

    task automatic test_pll();
        logic [5:0] expMult [4];
        expMult = '{brp_pkg::PLL_MULT_LOW, brp_pkg::PLL_MULT_MID, brp_pkg::PLL_MULT_HIGH, brp_pkg::PLL_MULT_HIGH};
        for (int b = 0; b < 4; b++)
        begin
            refBand = 2'(b);
            cycles(5);
            check("pllMult", 8'(expMult[b]), 8'(pllMult));
        end
    endtask

    task automatic pulse_wake();
        wakeEvent = 1'b1;
        cycles(5);
        wakeEvent = 1'b0;
        cycles(5);
    endtask

    task automatic test_power();
        check("cpuClockEn", 8'h01, 8'(stat.cpuClockEn));
        check("pllEn", 8'h01, 8'(stat.pllEn));
        ctrl.enterSuspend = 1'b1;
        cycles(1);
        ctrl.enterSuspend = 1'b0;
        cycles(3);
        check("suspend mode", 8'(brp_pkg::PM_SUSPEND), 8'(powerMode));
        check("usbPhyEn", 8'h01, 8'(stat.usbPhyEn));
        check("suspend cpuClockEn", 8'h00, 8'(stat.cpuClockEn));
        clear_flags();
        pulse_wake();
        check("suspend wake mode", 8'(brp_pkg::PM_NORMAL), 8'(powerMode));
        check("suspend wake pc", 8'h00, 8'(sawPc));
        ctrl.enterStandby = 1'b1;
        cycles(1);
        ctrl.enterStandby = 1'b0;
        cycles(3);
        check("standby mode", 8'(brp_pkg::PM_STANDBY), 8'(powerMode));
        check("standby pllEn", 8'h00, 8'(stat.pllEn));
        check("standby usbPhyEn", 8'h00, 8'(stat.usbPhyEn));
        clear_flags();
        pulse_wake();
        check("standby wake mode", 8'(brp_pkg::PM_NORMAL), 8'(powerMode));
        check("standby wake pc", 8'h01, 8'(sawPc));
        check("standby wake lost", 8'h00, 8'(sawLost));
        powerDown = 1'b1;
        cycles(5);
        powerDown = 1'b0;
        pulse_wake();
        check("powerdown mode", 8'(brp_pkg::PM_POWERDOWN), 8'(powerMode));
        check("powerdown firmwareLost", 8'h01, 8'(stat.firmwareLost));
        reset = 1'b1;
        cycles(5);
        reset = 1'b0;
        cycles(3);
        check("after reset mode", 8'(brp_pkg::PM_NORMAL), 8'(powerMode));
    endtask

    // Disabled, then kicked: silent across a few 32 kHz ticks
    task automatic test_wdog();
        clear_flags();
        ctrl.wdogDisable = 1'b1;
        cycles(3200);
        ctrl.wdogDisable = 1'b0;
        check("wdog disabled irq", 8'h00, 8'(sawIrq));
        check("wdog disabled pc", 8'h00, 8'(sawPc));
        ctrl.wdogKick = 1'b1;
        cycles(1);
        ctrl.wdogKick = 1'b0;
        cycles(3200);
        check("wdog kicked irq", 8'h00, 8'(sawIrq));
        check("wdog kicked mode", 8'(brp_pkg::PM_NORMAL), 8'(powerMode));
    endtask

    task automatic finish_test();
        $display("Checks %0d, failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        straps = '{brp_pkg::PIN_FLOAT, brp_pkg::PIN_HIGH, brp_pkg::PIN_HIGH};
        cycles(10);
        reset = 1'b0;
        cycles(3);
        test_pll();
        test_csi();
        test_boot(brp_pkg::PIN_FLOAT, brp_pkg::PIN_HIGH, brp_pkg::PIN_HIGH, brp_pkg::BOOT_USB, 1'b0, 1'b0);
        test_boot(brp_pkg::PIN_FLOAT, brp_pkg::PIN_HIGH, brp_pkg::PIN_FLOAT, brp_pkg::BOOT_I2C_USB, 1'b1, 1'b0);
        test_boot(brp_pkg::PIN_HIGH, brp_pkg::PIN_FLOAT, brp_pkg::PIN_FLOAT, brp_pkg::BOOT_I2C_ONLY, 1'b1, 1'b0);
        test_fallback(1'b0);
        test_boot(brp_pkg::PIN_LOW, brp_pkg::PIN_FLOAT, brp_pkg::PIN_HIGH, brp_pkg::BOOT_SPI_USB, 1'b0, 1'b1);
        test_fallback(1'b1);
        test_soft();
        test_power();
        test_wdog();
        finish_test();
    end

    // Whole run needs about seven thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        finish_test();
    end
endmodule
